// >>> bench/rss_host_model.sv
// Purpose: Host and EEPROM-probe model facing the reset source sequencer
// Assumes: Write strobes are one-cycle pulses launched on the rising edge
// Notes:   The probe answers a fixed count of cycles after each reload request
`timescale 1ns/1ps
`default_nettype none
module rss_host_model #(
   parameter int EE_CYC = 6
) (
   // Clock and status from the block
   input  wire logic ref_clk,
   input  wire logic readyBit,
   input  wire logic eepromReload,
   // Write strobes
   output logic      softResetWr,
   output logic      phyRstWr,
   output logic      phyBcrRstWr,
   output logic      sleepEnter,
   output logic      endianTestWr,
   // Probe finished
   output logic      eepromDone
);
   int eeCnt;

   initial begin
      {softResetWr, phyRstWr, phyBcrRstWr, sleepEnter, endianTestWr} = 5'h00;
      eepromDone = 1'h0;
      eeCnt = 0;
   end

   always @(posedge ref_clk) begin
      eepromDone <= (eepromReload !== 1'h1) && (eeCnt == 1);
      if (eepromReload === 1'h1) begin
         eeCnt <= EE_CYC;
      end else if (eeCnt > 0) begin
         eeCnt <= eeCnt - 1;
      end
   end

   // One write: 0 soft, 1 phy, 2 basic control, 3 sleep, 4 wake
   task automatic wr(input int sel);
      @(posedge ref_clk);
      softResetWr  <= (sel == 0);
      phyRstWr     <= (sel == 1);
      phyBcrRstWr  <= (sel == 2);
      sleepEnter   <= (sel == 3);
      endianTestWr <= (sel == 4);
      @(posedge ref_clk);
      {softResetWr, phyRstWr, phyBcrRstWr, sleepEnter, endianTestWr} <= 5'h00;
   endtask

   task automatic wait_ready(output int k);
      k = 0;
      while (readyBit !== 1'h1 && k < 500) begin
         @(negedge ref_clk);
         k++;
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/rss_reset_source_sequencer_tb_top.sv
// Purpose: Self-checking bench for the reset source sequencer
// Assumes: Shortened sequence counts; outputs sampled on the falling edge
// Notes:   Reload and strap-latch pulses are counted to see which source did what
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer_tb_top;
   localparam int POR   = 20;
   localparam int PHY   = 10;
   localparam int SOFT  = 5;
   localparam int WAKE  = 10;
   localparam int LIMIT = 2000;
   logic       ref_clk, rst_n, clkEn, hwResetPinN, hwResetPinDrv;
   logic [3:0] strapPins, strapVal;
   logic       softResetWr, phyRstWr, phyBcrRstWr, sleepEnter, endianTestWr;
   logic       eepromDone, readyBit, softResetBit, phyRstBit, phyBcrRstBit;
   logic       eepromBusyFlag, eepromReload, strapLatch;
   logic       pllRstN, hostBusRstN, preservedRstN, macIfRstN, macRstN, phyRstN;
   logic [5:0] rstVec;
   int         nMismatch, comparisons, cyc, reloads, latches, n;

   assign rstVec = {pllRstN, hostBusRstN, preservedRstN, macIfRstN, macRstN, phyRstN};

   rss_reset_source_sequencer #(.POR_CYC(POR), .PHY_CYC(PHY), .BCR_CYC(PHY),
      .WAKE_CYC(WAKE), .SOFT_CYC(SOFT)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .hwResetPinN(hwResetPinN),
      .hwResetPinDrv(hwResetPinDrv), .strapPins(strapPins), .softResetWr(softResetWr),
      .phyRstWr(phyRstWr), .phyBcrRstWr(phyBcrRstWr), .sleepEnter(sleepEnter),
      .endianTestWr(endianTestWr), .eepromDone(eepromDone), .readyBit(readyBit),
      .softResetBit(softResetBit), .phyRstBit(phyRstBit), .phyBcrRstBit(phyBcrRstBit),
      .eepromBusyFlag(eepromBusyFlag), .pllRstN(pllRstN), .hostBusRstN(hostBusRstN),
      .preservedRstN(preservedRstN), .macIfRstN(macIfRstN), .macRstN(macRstN),
      .phyRstN(phyRstN), .eepromReload(eepromReload), .strapLatch(strapLatch),
      .strapVal(strapVal));

   rss_host_model host (
      .ref_clk(ref_clk), .readyBit(readyBit), .eepromReload(eepromReload),
      .softResetWr(softResetWr), .phyRstWr(phyRstWr), .phyBcrRstWr(phyBcrRstWr),
      .sleepEnter(sleepEnter), .endianTestWr(endianTestWr), .eepromDone(eepromDone));

   always #10 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cyc++;
      if (eepromReload === 1'h1) reloads++;
      if (strapLatch === 1'h1) latches++;
      if (cyc == LIMIT) begin
         nMismatch++;
         close_out();
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return softResetBit;
         1: return phyRstBit;
         default: return phyBcrRstBit;
      endcase
   endfunction

   // Falling edges on which the chosen self-clearing bit reads high
   task automatic hi_len(input int sel, output int k);
      k = 0;
      while (pick(sel) === 1'h1 && k < 1000) begin
         k++;
         @(negedge ref_clk);
      end
   endtask

   initial begin
      ref_clk = 1'h0;
      rst_n = 1'h0;
      clkEn = 1'h1;
      hwResetPinN = 1'h1;
      hwResetPinDrv = 1'h1;
      strapPins = 4'hA;
      {nMismatch, comparisons, cyc, reloads, latches} = '0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("resetVec", rstVec, 8'h00);
      check("resetBusy", eepromBusyFlag, 8'h01);
      @(posedge ref_clk);
      rst_n <= 1'h1;
      host.wait_ready(n);
      check("porLate", n > POR, 8'h01);
      check("porReady", readyBit, 8'h01);
      check("porStraps", strapVal, 8'h0A);
      check("porCounts", {reloads[3:0], latches[3:0]}, 8'h11);
      check("porVec", rstVec, 8'h3F);
      // Soft reset: straps and the preserved domain must not move
      strapPins <= 4'h5;
      host.wr(0);
      @(negedge ref_clk);
      check("softRdy", readyBit, 8'h00);
      check("softVec", rstVec, 8'h29);
      check("softBusy", eepromBusyFlag, 8'h01);
      hi_len(0, n);
      check("softLen", n, SOFT);
      host.wr(1);
      repeat (2) @(negedge ref_clk);
      check("busyRefuse", phyRstBit, 8'h00);
      host.wait_ready(n);
      check("softStraps", strapVal, 8'h0A);
      check("softCounts", {reloads[3:0], latches[3:0]}, 8'h21);
      check("softBusyEnd", eepromBusyFlag, 8'h00);
      for (int s = 1; s < 3; s++) begin
         host.wr(s);
         @(negedge ref_clk);
         check("phyVec", rstVec, 8'h3E);
         check("phyRdy", readyBit, 8'h01);
         hi_len(s, n);
         check("phyLen", n, PHY);
         check("phyDone", rstVec, 8'h3F);
      end
      check("phyCounts", {reloads[3:0], latches[3:0]}, 8'h21);
      host.wr(3);
      @(negedge ref_clk);
      check("sleepRdy", readyBit, 8'h00);
      check("sleepVec", rstVec, 8'h3F);
      host.wr(1);
      repeat (2) @(negedge ref_clk);
      check("sleepRefuse", phyRstBit, 8'h00);
      host.wr(4);
      host.wait_ready(n);
      check("wakeTime", n, WAKE + 1);
      @(posedge ref_clk);
      hwResetPinN <= 1'h0;
      strapPins <= 4'h3;
      repeat (4) @(negedge ref_clk);
      check("pinVec", rstVec, 8'h00);
      check("pinRdy", readyBit, 8'h00);
      // Longer than the sequence, so a sequence running under the pin would show
      repeat (40) @(negedge ref_clk);
      check("pinHeld", readyBit, 8'h00);
      @(posedge ref_clk);
      hwResetPinN <= 1'h1;
      repeat (2) @(negedge ref_clk);
      check("syncHold", rstVec, 8'h00);
      host.wait_ready(n);
      check("pinRelease", rstVec, 8'h3F);
      check("pinStraps", strapVal, 8'h03);
      check("pinCounts", {reloads[3:0], latches[3:0]}, 8'h32);
      @(posedge ref_clk);
      hwResetPinDrv <= 1'h0;
      hwResetPinN <= 1'h0;
      repeat (10) @(negedge ref_clk);
      check("floatRdy", readyBit, 8'h01);
      check("floatVec", rstVec, 8'h3F);
      // A low enable freezes a running PHY reset; only enabled edges count down
      host.wr(1);
      clkEn <= 1'h0;
      repeat (20) @(negedge ref_clk);
      check("frozenPhy", {phyRstBit, phyRstN}, 8'h02);
      @(posedge ref_clk);
      clkEn <= 1'h1;
      @(negedge ref_clk);
      hi_len(1, n);
      check("frozenLen", n, PHY);
      close_out();
   end
endmodule
`default_nettype wire

// >>> hw/rss_pkg.sv
// Purpose: Shared constants and types for the reset source sequencer
// Assumes: 50 MHz reference clock
// Notes:   Cycle counts are derived from the times here; the top module may override them
package rss_pkg;

   localparam int CLK_HZ  = 50_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;

   // Sequence times in their own units
   localparam int POR_SEQ_TIME_US  = 22_000;
   localparam int SOFT_RST_TIME_NS = 2_000;
   localparam int PHY_RST_TIME_US  = 100;
   localparam int PHY_BCR_TIME_US  = 100;
   localparam int WAKE_TIME_US     = 2_000;

   // Derived cycle counts, none below one cycle
   localparam int POR_CYC  = POR_SEQ_TIME_US * CLK_MHZ;
   localparam int SOFT_CYC = (SOFT_RST_TIME_NS * CLK_MHZ) / 1_000;
   localparam int PHY_CYC  = PHY_RST_TIME_US * CLK_MHZ;
   localparam int BCR_CYC  = PHY_BCR_TIME_US * CLK_MHZ;
   localparam int WAKE_CYC = WAKE_TIME_US * CLK_MHZ;

   localparam int CNT_W   = 21;
   localparam int STRAP_W = 4;

   // Levels used for reset values
   localparam logic LVL_LO = 1'h0;
   localparam logic LVL_HI = 1'h1;

   typedef enum logic [2:0] {
      S_PINHOLD = 3'h0,
      S_PORSEQ  = 3'h1,
      S_EELOAD  = 3'h2,
      S_RUN     = 3'h3,
      S_SOFT    = 3'h4,
      S_SLEEP   = 3'h5,
      S_WAKE    = 3'h6
   } rss_state_t;

endpackage

// >>> hw/rss_reset_source_sequencer.sv
// Purpose: Steers four reset sources to the circuitry each affects and drives ready
// Assumes: Host strobes are one-cycle pulses on ref_clk; eepromDone comes from local logic
// Notes:   Host writes other than wake are ignored unless the device is running
// Notes on behaviour
// - Only four reset sources: pin, soft reset, PHY control bit, PHY basic-control bit.
// - Pin reset hits every domain, reloads EEPROM address, latches straps.
// - Soft reset hits bus interface, MAC layers; reloads EEPROM; leaves the rest.
// - Ready reads zero while pin low and until its sequence completes.
// - Undriven reset pin is pulled high and never resets.
// - Soft reset bit self-clears after about 2 us, ending the soft reset.
// - PHY control bit resets only the PHY, self-clears after about 100 us.
// - PHY basic-control reset bit resets only the PHY and self-clears.
// - After a wake write, ready sets within 2 ms.
// - Ready sets after the internal sequence of about 22 ms.
// - EEPROM probed after power-up, pin or soft reset; busy flag shows it.
// - Wake write leaves sleep; until ready only reads are honoured.
`timescale 1ns/1ps
`default_nettype none
module rss_reset_source_sequencer #(
   parameter int POR_CYC  = rss_pkg::POR_CYC,
   parameter int PHY_CYC  = rss_pkg::PHY_CYC,
   parameter int BCR_CYC  = rss_pkg::BCR_CYC,
   parameter int WAKE_CYC = rss_pkg::WAKE_CYC,
   parameter int SOFT_CYC = rss_pkg::SOFT_CYC,
   parameter int CNT_W    = rss_pkg::CNT_W,
   parameter int STRAP_W  = rss_pkg::STRAP_W
) (
   // Clock, power-on reset, enable
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               clkEn,
   // Reset pin and straps
   input  wire logic               hwResetPinN,
   input  wire logic               hwResetPinDrv,
   input  wire logic [STRAP_W-1:0] strapPins,
   // Host write strobes
   input  wire logic               softResetWr,
   input  wire logic               phyRstWr,
   input  wire logic               phyBcrRstWr,
   input  wire logic               sleepEnter,
   input  wire logic               endianTestWr,
   // EEPROM probe
   input  wire logic               eepromDone,
   // Status bits
   output logic                    readyBit,
   output logic                    softResetBit,
   output logic                    phyRstBit,
   output logic                    phyBcrRstBit,
   output logic                    eepromBusyFlag,
   // Domain resets
   output logic                    pllRstN,
   output logic                    hostBusRstN,
   output logic                    preservedRstN,
   output logic                    macIfRstN,
   output logic                    macRstN,
   output logic                    phyRstN,
   // Reload and straps
   output logic                    eepromReload,
   output logic                    strapLatch,
   output logic      [STRAP_W-1:0] strapVal
);

   rss_pkg::rss_state_t state_q, state_d;
   logic [CNT_W-1:0]   seqCnt_q, seqCnt_d;
   logic [CNT_W-1:0]   phyCnt_q, phyCnt_d;
   logic [CNT_W-1:0]   bcrCnt_q, bcrCnt_d;
   logic               phyBit_q, phyBit_d;
   logic               bcrBit_q, bcrBit_d;
   logic               ready_q, ready_d;
   logic               soft_q, soft_d;
   logic               busy_q, busy_d;
   logic               pll_q, pll_d;
   logic               hostBus_q, hostBus_d;
   logic               preserved_q, preserved_d;
   logic               macIf_q, macIf_d;
   logic               mac_q, mac_d;
   logic               phy_q, phy_d;
   logic               reload_q, reload_d;
   logic               strapP_q, strapP_d;
   logic [STRAP_W-1:0] strapV_q, strapV_d;
   logic               pinEff;
   logic               pinSync;
   logic [STRAP_W-1:0] strapSync;
   logic               hold;
   logic               wrOk;
   logic               leaveHold;

   function automatic logic [CNT_W-1:0] cntDown(input logic [CNT_W-1:0] v);
      return v - CNT_W'(1);
   endfunction

   function automatic logic [CNT_W-1:0] cntLoad(input int cycles);
      return CNT_W'(cycles - 1);
   endfunction

   // Self-clearing bit and its count as {bit, count}; a write wins over the clear
   function automatic logic [CNT_W:0] selfClr(input logic bitQ, input logic [CNT_W-1:0] cnt,
                                              input logic wr, input int cycles);
      logic [CNT_W:0] nxt;
      nxt = {bitQ, cnt};
      if (bitQ) begin
         nxt = (cnt == '0) ? {rss_pkg::LVL_LO, cnt} : {bitQ, cntDown(cnt)};
      end
      if (wr) begin
         nxt = {rss_pkg::LVL_HI, cntLoad(cycles)};
      end
      return nxt;
   endfunction

   assign pinEff = hwResetPinDrv ? hwResetPinN : rss_pkg::LVL_HI;

   // synchronised deassertion; a low reset value keeps pin-hold for two edges
   rss_sync #(.W(STRAP_W + 1), .RST_VAL('0)) u_pinSync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .din     ({pinEff, strapPins}),
      .dout    ({pinSync, strapSync})
   );

   // Host writes only count once ready; guards against writes while asleep
   assign wrOk = (state_q == rss_pkg::S_RUN);

   // Main sequence
   always_comb begin
      state_d  = state_q;
      // Count rests at zero once its timed state is over
      seqCnt_d = (seqCnt_q == '0) ? seqCnt_q : cntDown(seqCnt_q);
      unique case (state_q)
         rss_pkg::S_PINHOLD: begin
            state_d  = rss_pkg::S_PORSEQ;
            seqCnt_d = cntLoad(POR_CYC);
         end
         rss_pkg::S_PORSEQ: begin
            if (seqCnt_q == '0) begin
               state_d = rss_pkg::S_EELOAD;
            end
         end
         rss_pkg::S_EELOAD: begin
            if (eepromDone) begin
               state_d = rss_pkg::S_RUN;
            end
         end
         rss_pkg::S_RUN: begin
            if (softResetWr) begin
               state_d  = rss_pkg::S_SOFT;
               seqCnt_d = cntLoad(SOFT_CYC);
            end else if (sleepEnter) begin
               state_d = rss_pkg::S_SLEEP;
            end
         end
         rss_pkg::S_SOFT: begin
            if (seqCnt_q == '0) begin
               state_d = rss_pkg::S_EELOAD;
            end
         end
         rss_pkg::S_SLEEP: begin
            if (endianTestWr) begin
               state_d  = rss_pkg::S_WAKE;
               seqCnt_d = cntLoad(WAKE_CYC);
            end
         end
         rss_pkg::S_WAKE: begin
            if (seqCnt_q == '0) begin
               state_d = rss_pkg::S_RUN;
            end
         end
         default: begin
            state_d  = rss_pkg::S_PINHOLD;
            seqCnt_d = '0;
         end
      endcase
      if (!pinSync) begin
         state_d  = rss_pkg::S_PINHOLD;
         seqCnt_d = '0;
      end
   end

   // PHY-only resets; a new write wins over the self-clear
   always_comb begin
      {phyBit_d, phyCnt_d} = selfClr(phyBit_q, phyCnt_q, phyRstWr && wrOk, PHY_CYC);
      {bcrBit_d, bcrCnt_d} = selfClr(bcrBit_q, bcrCnt_q, phyBcrRstWr && wrOk, BCR_CYC);
      if (state_d == rss_pkg::S_PINHOLD) begin
         phyBit_d = rss_pkg::LVL_LO;
         bcrBit_d = rss_pkg::LVL_LO;
         phyCnt_d = '0;
         bcrCnt_d = '0;
      end
   end

   // Outputs follow the next state so they line up with state_q
   always_comb begin
      hold      = (state_d == rss_pkg::S_PINHOLD);
      leaveHold = (state_q == rss_pkg::S_PINHOLD) && !hold;
      ready_d  = (state_d == rss_pkg::S_RUN);
      soft_d   = (state_d == rss_pkg::S_SOFT);
      busy_d   = hold || (state_d == rss_pkg::S_PORSEQ) || soft_d
                 || (state_d == rss_pkg::S_EELOAD);
      pll_d       = !hold;
      preserved_d = !hold;
      hostBus_d   = !(hold || soft_d);
      macIf_d     = !(hold || soft_d);
      mac_d       = !(hold || soft_d);
      phy_d       = !(hold || phyBit_d || bcrBit_d);
      reload_d    = (state_d == rss_pkg::S_EELOAD) && (state_q != rss_pkg::S_EELOAD);
      strapP_d = leaveHold;
      strapV_d = leaveHold ? strapSync : strapV_q;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= rss_pkg::S_PINHOLD;
         seqCnt_q    <= '0;
         phyCnt_q    <= '0;
         bcrCnt_q    <= '0;
         phyBit_q    <= rss_pkg::LVL_LO;
         bcrBit_q    <= rss_pkg::LVL_LO;
         ready_q     <= rss_pkg::LVL_LO;
         soft_q      <= rss_pkg::LVL_LO;
         busy_q      <= rss_pkg::LVL_HI;
         pll_q       <= rss_pkg::LVL_LO;
         hostBus_q   <= rss_pkg::LVL_LO;
         preserved_q <= rss_pkg::LVL_LO;
         macIf_q     <= rss_pkg::LVL_LO;
         mac_q       <= rss_pkg::LVL_LO;
         phy_q       <= rss_pkg::LVL_LO;
         reload_q    <= rss_pkg::LVL_LO;
         strapP_q    <= rss_pkg::LVL_LO;
         strapV_q    <= '0;
      end else if (clkEn) begin
         state_q     <= state_d;
         seqCnt_q    <= seqCnt_d;
         phyCnt_q    <= phyCnt_d;
         bcrCnt_q    <= bcrCnt_d;
         phyBit_q    <= phyBit_d;
         bcrBit_q    <= bcrBit_d;
         ready_q     <= ready_d;
         soft_q      <= soft_d;
         busy_q      <= busy_d;
         pll_q       <= pll_d;
         hostBus_q   <= hostBus_d;
         preserved_q <= preserved_d;
         macIf_q     <= macIf_d;
         mac_q       <= mac_d;
         phy_q       <= phy_d;
         reload_q    <= reload_d;
         strapP_q    <= strapP_d;
         strapV_q    <= strapV_d;
      end
   end

   assign readyBit       = ready_q;
   assign softResetBit   = soft_q;
   assign phyRstBit      = phyBit_q;
   assign phyBcrRstBit   = bcrBit_q;
   assign eepromBusyFlag = busy_q;
   assign pllRstN        = pll_q;
   assign hostBusRstN    = hostBus_q;
   assign preservedRstN  = preserved_q;
   assign macIfRstN      = macIf_q;
   assign macRstN        = mac_q;
   assign phyRstN        = phy_q;
   assign eepromReload   = reload_q;
   assign strapLatch     = strapP_q;
   assign strapVal       = strapV_q;

   // Assertion helpers: enabled cycles spent in soft reset and in the PHY control reset
   logic [CNT_W-1:0] softLen_q;
   logic [CNT_W-1:0] phyLen_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         softLen_q <= '0;
         phyLen_q  <= '0;
      end else if (clkEn) begin
         softLen_q <= soft_q ? softLen_q + CNT_W'(1) : '0;
         phyLen_q  <= (phyRstWr && wrOk) ? '0 : (phyBit_q ? phyLen_q + CNT_W'(1) : '0);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   pin_ready_low_a: assert property (!pinSync && clkEn |=> !readyBit)
      else $error("ready set while reset pin low");
   pin_all_domains_a: assert property (state_q == rss_pkg::S_PINHOLD |->
      !pllRstN && !hostBusRstN && !preservedRstN && !macIfRstN && !macRstN && !phyRstN)
      else $error("pin reset left a domain running");
   soft_domains_a: assert property (state_q == rss_pkg::S_SOFT |->
      !hostBusRstN && !macIfRstN && !macRstN && pllRstN && preservedRstN && $stable(strapVal))
      else $error("soft reset steered to wrong domains");
   soft_length_a: assert property ($fell(softResetBit) && state_q == rss_pkg::S_EELOAD
      |-> softLen_q == CNT_W'(SOFT_CYC))
      else $error("soft reset bit cleared at wrong time");
   phy_length_a: assert property ($fell(phyRstBit) && state_q != rss_pkg::S_PINHOLD
      |-> phyLen_q == CNT_W'(PHY_CYC))
      else $error("phy reset bit cleared at wrong time");
   phy_only_a: assert property ((phyRstBit || phyBcrRstBit) && state_q == rss_pkg::S_RUN
      |-> !phyRstN && hostBusRstN && macRstN && macIfRstN && pllRstN)
      else $error("phy reset touched other domains");
   wake_bound_a: assert property (state_q == rss_pkg::S_WAKE |->
      seqCnt_q < CNT_W'(WAKE_CYC) && !readyBit)
      else $error("wake sequence exceeds its bound");
   por_exit_a: assert property (state_q == rss_pkg::S_PORSEQ && seqCnt_q == '0
      && clkEn && pinSync |=> state_q == rss_pkg::S_EELOAD && eepromReload && !readyBit)
      else $error("internal sequence did not hand over to reload");
   reload_ready_a: assert property (state_q == rss_pkg::S_EELOAD && eepromDone && clkEn
      && pinSync |=> readyBit && !eepromBusyFlag)
      else $error("ready not set after reload");
   sleep_write_a: assert property (state_q == rss_pkg::S_SLEEP && (softResetWr || phyRstWr)
      && clkEn && !endianTestWr |=> !softResetBit && !readyBit && !$rose(phyRstBit))
      else $error("write honoured while asleep");
   strap_hold_a: assert property ($changed(strapVal) |->
      $past(state_q) == rss_pkg::S_PINHOLD)
      else $error("straps changed outside pin release");

   soft_done_c: cover property ($fell(softResetBit) ##[1:50] $rose(readyBit));
   phy_done_c: cover property ($fell(phyRstBit) && readyBit);
   wake_done_c: cover property (state_q == rss_pkg::S_WAKE ##1 readyBit);

endmodule
`default_nettype wire

// >>> hw/rss_sync.sv
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are quasi-static levels from outside the clock domain
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rss_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and control
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         clkEn,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = clkEn ? din : meta_q;
      sync_d = clkEn ? meta_q : sync_q;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;

endmodule
`default_nettype wire
